// >>> verilog/extra_dma_pkg.sv
// Constants shared by the extra FIFO readout engine.
package extra_dma_pkg;
   // Register offsets.
   localparam logic [6:0] CMD_OFFSET = 7'h64;
   localparam logic [6:0] STATUS_OFFSET = 7'h6E;
   // Command word bit positions.
   localparam int START_BIT = 20;
   localparam int WAIT_BIT = 21;
   localparam int STOP_BIT = 22;
   localparam int POLL_BIT = 23;
   // Status word bit positions.
   localparam int BLOCK_BIT = 12;
   localparam int DONE_BIT = 13;
   localparam int OVERRUN_BIT = 14;
   localparam int FAULT_BIT = 15;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   // Storage and FIFO shape.
   localparam int SAMPLE_BITS = 16;
   localparam logic [31:0] SAMPLE_BYTES = 32'h0000_0002;
   localparam int FIFO_DEPTH = 16;
   // Acquisition setup limits, in samples; memory select and divider bounds are plain values.
   localparam logic [34:0] MIN_TOTAL = 35'h0_0000_0010;
   localparam logic [34:0] MIN_PRE = 35'h0_0000_0008;
   localparam logic [34:0] MAX_PRE_ONE = 35'h0_0000_2000;
   localparam logic [34:0] MAX_PRE_TWO = 35'h0_0000_1000;
   localparam logic [34:0] MIN_POST = 35'h0_0000_0008;
   localparam logic [34:0] MAX_POST = 35'h1_FFFF_FFF8;
   localparam logic [34:0] MIN_SEG = 35'h0_0000_0010;
   localparam logic [34:0] MEM_BASE = 35'h0_0800_0000;
   localparam logic [2:0] MEM_SEL_MAX = 3'h4;
   localparam logic [17:0] DIV_MIN = 18'h0_0008;
   localparam logic [17:0] DIV_MAX = 18'h1_FFF8;
   localparam logic [17:0] DIV_RESET = 18'h0_0000;
endpackage : extra_dma_pkg

// >>> verilog/extra_fifo.sv
// Parameterised FIFO whose read data come out of a register.
module extra_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [CW-1:0] count;
   logic push;
   logic pop;

   assign inReady = count != FULL;
   assign push = inValid && inReady;
   // The output register is refilled whenever it is empty or being taken.
   assign pop = (count != '0) && (!outValid || outReady);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= rdPtr + 1'b1;
         end
         count <= count + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         outValid <= 1'b0;
         outData <= '0;
      end else if (pop) begin
         outValid <= 1'b1;
         outData <= mem[rdPtr];
      end else if (outReady) begin
         outValid <= 1'b0;
      end
   end
endmodule : extra_fifo

// >>> verilog/extra_dma_engine.sv
// Extra FIFO busmaster readout engine for dual_timebase slow data.
// What this block does
// - Each stored sample takes two bytes
// - Total size limits in standard modes
// - Pretrigger 8 to 8k or 4k
// - Posttrigger limits, memory cap in multi
// - Segment size minimum, step, caps
// - Streaming loop count zero means endless
// - Memory figure equals installed memory
// - Slow samples and timestamps share FIFO
// - Own DMA engine, independent of main
// - Command bits combine in one write
// - Start bit begins extra DMA
// - Wait until block, end or timeout
// - Stop bit aborts, data then invalid
// - Block ready when notify block present
// - Done flag only with zero notify
// - Overrun flag on streaming FIFO overflow
// - Fault flag on internal transfer error
// - Overrun halts extra transfer at once
// - Slow rate is fast rate over divider
// - Card to host only, no offset
module extra_dma_engine (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [6:0] regAddr,
   input wire logic regWrite,
   input wire logic [31:0] regWdata,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic sampleStrobe,
   input wire logic [15:0] sampleData,
   input wire logic acqActive,
   input wire logic tsValid,
   output logic tsReady,
   input wire logic [15:0] tsData,
   input wire logic [17:0] slowRateDivider,
   input wire logic streamMode,
   input wire logic multiMode,
   input wire logic twoChannels,
   input wire logic [2:0] memSel,
   input wire logic [34:0] totalSampleCount,
   input wire logic [34:0] afterTriggerCount,
   input wire logic [34:0] segmentLength,
   input wire logic [31:0] repeatCount,
   output logic setupOk,
   output logic endless,
   input wire logic [31:0] bufferBase,
   input wire logic [31:0] bufferLength,
   input wire logic [31:0] notifySize,
   input wire logic [31:0] waitTimeout,
   input wire logic busFault,
   output logic dmaValid,
   input wire logic dmaReady,
   output logic [31:0] dmaAddr,
   output logic [15:0] dmaData,
   output logic running,
   output logic pollMode,
   output logic waitBusy,
   output logic waitExpired
);
   logic cmdWrite;
   logic startCmd;
   logic waitCmd;
   logic stopCmd;
   logic pollCmd;
   logic startOk;
   logic [17:0] divCount;
   logic slowTick;
   logic fifoInValid;
   logic fifoInReady;
   logic [15:0] fifoInData;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [15:0] fifoOutData;
   logic dmaTake;
   logic overrunEvent;
   logic faultEvent;
   logic [31:0] bytesDone;
   logic [31:0] blockCount;
   logic blockFlag;
   logic doneFlag;
   logic overrunFlag;
   logic faultFlag;
   logic blockTaken;
   logic lastWord;
   logic [31:0] waitCount;
   logic [31:0] statusWord;
   logic [34:0] memFig;
   logic [34:0] memHalf;
   logic [34:0] preLen;
   logic [34:0] preMax;
   logic [34:0] postMax;
   logic [34:0] segMax;
   logic next_setupOk;

   // All extra-transfer bits are taken from one write; others are ignored.
   assign cmdWrite = regWrite && (regAddr == extra_dma_pkg::CMD_OFFSET);
   assign stopCmd = cmdWrite && regWdata[extra_dma_pkg::STOP_BIT];
   assign startCmd = cmdWrite && regWdata[extra_dma_pkg::START_BIT];
   assign waitCmd = cmdWrite && regWdata[extra_dma_pkg::WAIT_BIT];
   assign pollCmd = cmdWrite && regWdata[extra_dma_pkg::POLL_BIT];
   // Start is refused while polling or beside a poll, so the two never share a transfer.
   assign startOk = startCmd && !stopCmd && !pollCmd && !running && !pollMode
                    && setupOk;

   // Installed memory doubles with each select step.
   always_comb begin
      memFig = extra_dma_pkg::MEM_BASE << memSel;
      memHalf = twoChannels ? (memFig >> 1) : memFig;
      preLen = segmentLength - afterTriggerCount;
      preMax = twoChannels ? extra_dma_pkg::MAX_PRE_TWO : extra_dma_pkg::MAX_PRE_ONE;
      postMax = (multiMode && !streamMode) ? (memHalf >> 1) : extra_dma_pkg::MAX_POST;
      segMax = streamMode ? (multiMode ? segmentLength : extra_dma_pkg::MAX_POST)
                          : (memHalf >> 1);
      next_setupOk = (memSel <= extra_dma_pkg::MEM_SEL_MAX);
      next_setupOk = next_setupOk && (slowRateDivider >= extra_dma_pkg::DIV_MIN)
                     && (slowRateDivider <= extra_dma_pkg::DIV_MAX)
                     && (slowRateDivider[2:0] == 3'h0);
      if (!streamMode) begin
         next_setupOk = next_setupOk && (totalSampleCount >= extra_dma_pkg::MIN_TOTAL)
                        && (totalSampleCount[2:0] == 3'h0)
                        && (totalSampleCount <= memHalf);
      end
      if (multiMode || streamMode) begin
         next_setupOk = next_setupOk && (segmentLength > afterTriggerCount)
                        && (preLen >= extra_dma_pkg::MIN_PRE) && (preLen <= preMax)
                        && (preLen[2:0] == 3'h0);
         next_setupOk = next_setupOk && (segmentLength >= extra_dma_pkg::MIN_SEG)
                        && (segmentLength[2:0] == 3'h0)
                        && (segmentLength <= segMax);
      end
      if (multiMode || !streamMode) begin
         next_setupOk = next_setupOk && (afterTriggerCount >= extra_dma_pkg::MIN_POST)
                        && (afterTriggerCount[2:0] == 3'h0)
                        && (afterTriggerCount <= postMax);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         setupOk <= 1'b0;
         endless <= 1'b0;
      end else begin
         setupOk <= next_setupOk;
         // Loop count only matters when streaming; zero runs without end.
         endless <= streamMode && (repeatCount == 32'h0000_0000);
      end
   end

   // Slow clock: one slow sample every divider fast samples.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         divCount <= extra_dma_pkg::DIV_RESET;
      end else if (!acqActive) begin
         divCount <= extra_dma_pkg::DIV_RESET;
      end else if (sampleStrobe) begin
         divCount <= slowTick ? extra_dma_pkg::DIV_RESET : divCount + 18'h0_0001;
      end
   end
   assign slowTick = acqActive && sampleStrobe && (divCount + 18'h0_0001 >= slowRateDivider);

   // Slow samples and timestamps share one FIFO; samples cannot wait.
   assign fifoInValid = slowTick || tsValid;
   assign fifoInData = slowTick ? sampleData : tsData;
   assign tsReady = fifoInReady && !slowTick;
   assign overrunEvent = slowTick && !fifoInReady && streamMode;

   extra_fifo #(
      .WIDTH(extra_dma_pkg::SAMPLE_BITS),
      .DEPTH(extra_dma_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // This engine only writes host memory and runs beside the main engine.
   assign dmaValid = running && fifoOutValid;
   assign fifoOutReady = running && dmaReady;
   assign dmaData = fifoOutData;
   assign dmaTake = dmaValid && dmaReady;
   assign lastWord = dmaTake && (bytesDone + extra_dma_pkg::SAMPLE_BYTES >= bufferLength);
   assign faultEvent = running && busFault;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         running <= 1'b0;
      end else if (stopCmd) begin
         running <= 1'b0;
      end else if (overrunEvent || faultEvent) begin
         running <= 1'b0;
      end else if (startOk) begin
         running <= 1'b1;
      end else if (lastWord) begin
         running <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pollMode <= 1'b0;
      end else if (pollCmd && !running) begin
         pollMode <= 1'b1;
      end else if (stopCmd) begin
         pollMode <= 1'b0;
      end
   end

   // Address walks up from the buffer start; there is no offset.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dmaAddr <= 32'h0000_0000;
         bytesDone <= 32'h0000_0000;
      end else if (startOk || stopCmd) begin
         dmaAddr <= bufferBase;
         bytesDone <= 32'h0000_0000;
      end else if (dmaTake) begin
         dmaAddr <= dmaAddr + extra_dma_pkg::SAMPLE_BYTES;
         bytesDone <= bytesDone + extra_dma_pkg::SAMPLE_BYTES;
      end
   end

   // A status read that shows block ready hands one notify block over.
   assign blockFlag = (notifySize != 32'h0000_0000) && (blockCount >= notifySize);
   assign blockTaken = regRead && (regAddr == extra_dma_pkg::STATUS_OFFSET) && blockFlag;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         blockCount <= 32'h0000_0000;
      end else if (startOk || stopCmd) begin
         blockCount <= 32'h0000_0000;
      end else begin
         blockCount <= blockCount
                       + (dmaTake ? extra_dma_pkg::SAMPLE_BYTES : 32'h0000_0000)
                       - (blockTaken ? notifySize : 32'h0000_0000);
      end
   end

   // Sticky flags clear on a new start; an event in that cycle still sets.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         doneFlag <= 1'b0;
      end else if (lastWord && (notifySize == 32'h0000_0000) && !stopCmd) begin
         doneFlag <= 1'b1;
      end else if (startOk) begin
         doneFlag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         overrunFlag <= 1'b0;
      end else if (overrunEvent) begin
         overrunFlag <= 1'b1;
      end else if (startOk) begin
         overrunFlag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         faultFlag <= 1'b0;
      end else if (faultEvent) begin
         faultFlag <= 1'b1;
      end else if (startOk) begin
         faultFlag <= 1'b0;
      end
   end

   // Wait holds until a block is ready, the transfer ends, or timeout.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         waitBusy <= 1'b0;
         waitExpired <= 1'b0;
         waitCount <= 32'h0000_0000;
      end else if (waitCmd && !stopCmd) begin
         waitBusy <= 1'b1;
         waitExpired <= 1'b0;
         waitCount <= 32'h0000_0000;
      end else if (waitBusy) begin
         waitCount <= waitCount + 32'h0000_0001;
         if (blockFlag || !running || stopCmd) begin
            waitBusy <= 1'b0;
         end else if ((waitTimeout != 32'h0000_0000)
                      && (waitCount + 32'h0000_0001 >= waitTimeout)) begin
            waitBusy <= 1'b0;
            waitExpired <= 1'b1;
         end
      end
   end

   // Each condition drives its own bit, so several may show at once.
   always_comb begin
      statusWord = extra_dma_pkg::STATUS_RESET;
      statusWord[extra_dma_pkg::BLOCK_BIT] = blockFlag;
      statusWord[extra_dma_pkg::DONE_BIT] = doneFlag;
      statusWord[extra_dma_pkg::OVERRUN_BIT] = overrunFlag;
      statusWord[extra_dma_pkg::FAULT_BIT] = faultFlag;
   end

   // The command word is write only and reads as zero, like every offset except the status word.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         regRdata <= extra_dma_pkg::STATUS_RESET;
      end else if (regRead) begin
         regRdata <= (regAddr == extra_dma_pkg::STATUS_OFFSET) ? statusWord
                                                                : 32'h0000_0000;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_stop_halts: assert property (stopCmd |=> !running && !dmaValid)
      else $error("transfer still running after stop");
   a_overrun_halts: assert property (overrunEvent |=> !running ##0 overrunFlag)
      else $error("overrun did not halt transfer");
   a_start_runs: assert property (
      startOk && !overrunEvent |=> running && bytesDone == 32'h0000_0000)
      else $error("start did not begin transfer");
   a_done_zero_notify: assert property (
      $rose(doneFlag) |-> $past(notifySize) == 32'h0000_0000)
      else $error("done flag with nonzero notify size");
   a_block_amount: assert property (
      statusWord[extra_dma_pkg::BLOCK_BIT] |-> bytesDone >= notifySize)
      else $error("block ready without a full block");
   a_byte_step: assert property (
      dmaTake && !stopCmd |=> bytesDone == $past(bytesDone) + 32'h0000_0002)
      else $error("byte count not two per sample");
   a_card_to_host: assert property (dmaValid |-> running && !pollMode)
      else $error("data offered while not running");
   a_wait_release: assert property (
      waitBusy && !waitCmd && (blockFlag || !running) |=> !waitBusy)
      else $error("wait not released");
   a_fault_sticky: assert property (
      faultEvent |=> faultFlag ##1 (faultFlag || $past(startOk)))
      else $error("fault flag not kept");
   a_pre_limit: assert property (
      setupOk && $past(twoChannels && multiMode)
      |-> $past(preLen) <= extra_dma_pkg::MAX_PRE_TWO)
      else $error("pretrigger over two channel limit");

   c_transfer_done: cover property (startOk ##[1:200] doneFlag);
   c_overrun: cover property (running ##1 overrunEvent);
   c_wait_timeout: cover property ($rose(waitExpired));
   c_flags_together: cover property (overrunFlag && faultFlag);
endmodule : extra_dma_engine

// >>> verif/host_memory.sv
// Host memory model that takes extra data words by busmaster DMA.
module host_memory (
   input wire logic clk,
   input wire logic nrst,
   input wire logic dmaValid,
   input wire logic [31:0] dmaAddr,
   input wire logic [15:0] dmaData,
   input wire logic slow,
   input wire logic hold,
   output logic dmaReady,
   output int nWords
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [0:63];
   // A slow host accepts every other cycle; hold stalls it completely.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dmaReady <= 1'b0;
         nWords <= 0;
      end else begin
         dmaReady <= !hold && (!slow || !dmaReady);
         if (dmaValid && dmaReady) begin
            nWords <= nWords + 1;
         end
      end
   end
   // Words only ever flow towards the host.
   always_ff @(posedge clk) begin
      if (dmaValid && dmaReady) begin
         mem[dmaAddr[6:1]] <= dmaData;
      end
   end
endmodule : host_memory

// >>> verif/tb_extra_dma_engine.sv
// Self-checking bench for the extra FIFO readout engine.
module tb_extra_dma_engine;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] CMDA = extra_dma_pkg::CMD_OFFSET;
   localparam logic [6:0] STA = extra_dma_pkg::STATUS_OFFSET;
   localparam logic [31:0] START = 32'h0000_0001 << extra_dma_pkg::START_BIT;
   localparam logic [31:0] WAIT = 32'h0000_0001 << extra_dma_pkg::WAIT_BIT;
   localparam logic [31:0] STOP = 32'h0000_0001 << extra_dma_pkg::STOP_BIT;
   localparam logic [31:0] POLL = 32'h0000_0001 << extra_dma_pkg::POLL_BIT;
   logic clk, nrst, regWrite, regRead, sampleStrobe, acqActive, tsValid, tsReady;
   logic streamMode, multiMode, twoChannels, busFault, slow, hold, dmaValid, dmaReady;
   logic setupOk, endless, running, pollMode, waitBusy, waitExpired;
   logic [6:0] regAddr;
   logic [2:0] memSel;
   logic [17:0] slowRateDivider;
   logic [15:0] sampleData, tsData, dmaData;
   logic [34:0] totalSampleCount, afterTriggerCount, segmentLength;
   logic [31:0] regWdata, regRdata, repeatCount, bufferBase, bufferLength;
   logic [31:0] notifySize, waitTimeout, dmaAddr, q;
   int nWords, n_fail, tests_run, got, n;
   extra_dma_engine DUT (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrite(regWrite),
      .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
      .sampleStrobe(sampleStrobe), .sampleData(sampleData), .acqActive(acqActive),
      .tsValid(tsValid), .tsReady(tsReady), .tsData(tsData),
      .slowRateDivider(slowRateDivider), .streamMode(streamMode), .multiMode(multiMode),
      .twoChannels(twoChannels), .memSel(memSel), .totalSampleCount(totalSampleCount),
      .afterTriggerCount(afterTriggerCount), .segmentLength(segmentLength),
      .repeatCount(repeatCount), .setupOk(setupOk), .endless(endless),
      .bufferBase(bufferBase), .bufferLength(bufferLength), .notifySize(notifySize),
      .waitTimeout(waitTimeout), .busFault(busFault), .dmaValid(dmaValid),
      .dmaReady(dmaReady), .dmaAddr(dmaAddr), .dmaData(dmaData), .running(running),
      .pollMode(pollMode), .waitBusy(waitBusy), .waitExpired(waitExpired));
   host_memory host (.clk(clk), .nrst(nrst), .dmaValid(dmaValid), .dmaAddr(dmaAddr),
      .dmaData(dmaData), .slow(slow), .hold(hold), .dmaReady(dmaReady), .nWords(nWords));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task chk(input string name, input logic [34:0] exp, input logic [34:0] seen);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task wr(input logic [31:0] d);
      @(posedge clk);
      regAddr <= CMDA;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr
   task rd(input logic [6:0] a);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      q = regRdata;
   endtask : rd
   // Offers timestamps until the FIFO refuses or count words went in.
   task push(input int count);
      got = 0;
      for (int i = 0; i < count; i++) begin
         @(posedge clk);
         tsData <= 16'h00A0 + i[15:0];
         tsValid <= 1'b1;
         @(negedge clk);
         if (tsReady !== 1'b1) break;
         got++;
      end
      @(posedge clk);
      tsValid <= 1'b0;
   endtask : push
   task wait_idle(input int lim);
      for (int i = 0; i < lim && running === 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
   endtask : wait_idle
   task s(input logic mm, tc, input logic [2:0] ms, input logic [34:0] tot, seg, post,
         input logic e);
      @(posedge clk);
      multiMode <= mm;
      twoChannels <= tc;
      memSel <= ms;
      totalSampleCount <= tot;
      segmentLength <= seg;
      afterTriggerCount <= post;
      repeat (2) @(posedge clk);
      #1;
      chk("setupOk", e, setupOk);
   endtask : s
   task t_reset;
      rd(STA);
      chk("status", extra_dma_pkg::STATUS_RESET, q);
      rd(CMDA);
      chk("cmdRead", 0, q);
      rd(7'h10);
      chk("unmapped", 0, q);
      $display("reset test done");
   endtask : t_reset
   task t_fill;
      n = nWords;
      push(20);
      chk("fifoWords", extra_dma_pkg::FIFO_DEPTH + 1, got);
      wr(START);
      chk("startAddr", bufferBase, dmaAddr);
      wait_idle(200);
      chk("words", 17, nWords - n);
      for (int i = 0; i < 17; i++) chk("hostWord", 16'h00A0 + i, host.mem[i]);
      rd(STA);
      chk("doneStatus", 32'h0000_2000, q);
      $display("fill test done");
   endtask : t_fill
   task t_block;
      notifySize <= 32'h0000_0008;
      bufferLength <= 32'h0000_0100;
      wr(START | WAIT);
      @(posedge clk);
      #1;
      chk("waitBusy", 1, waitBusy);
      push(4);
      for (n = 0; n < 50 && waitBusy === 1'b1; n++) @(posedge clk);
      #1;
      chk("waitEnd", 0, waitBusy);
      chk("expired", 0, waitExpired);
      rd(STA);
      chk("block", 1, q[extra_dma_pkg::BLOCK_BIT]);
      rd(STA);
      chk("blockUsed", 0, q[extra_dma_pkg::BLOCK_BIT]);
      @(posedge clk);
      busFault <= 1'b1;
      @(posedge clk);
      busFault <= 1'b0;
      rd(STA);
      chk("fault", 1, q[extra_dma_pkg::FAULT_BIT]);
      wr(START);
      chk("restarted", 1, running);
      wr(STOP | START);
      chk("stopped", 0, running);
      chk("stopAddr", bufferBase, dmaAddr);
      $display("block test done");
   endtask : t_block
   task t_timeout;
      waitTimeout <= 32'h0000_0014;
      wr(START | WAIT);
      @(posedge clk);
      for (n = 0; n < 60 && waitBusy === 1'b1; n++) @(posedge clk);
      #1;
      chk("expired", 1, waitExpired);
      chk("notEarly", 1, n >= 15);
      chk("notLate", 1, n <= 21);
      wr(STOP);
      waitTimeout <= 32'h0000_0000;
      notifySize <= 32'h0000_0000;
      $display("timeout test done");
   endtask : t_timeout
   task t_overrun;
      hold <= 1'b1;
      streamMode <= 1'b1;
      bufferLength <= 32'h0000_0022;
      repeatCount <= 32'h0000_0005;
      repeat (2) @(posedge clk);
      #1;
      chk("counted", 0, endless);
      repeatCount <= 32'h0000_0000;
      repeat (2) @(posedge clk);
      #1;
      chk("endless", 1, endless);
      wr(START);
      @(posedge clk);
      acqActive <= 1'b1;
      sampleStrobe <= 1'b1;
      wait_idle(300);
      chk("halted", 0, running);
      // Strobes pause so the restart and the fault land before the next overrun.
      sampleStrobe <= 1'b0;
      wr(START);
      chk("rerun", 1, running);
      @(posedge clk);
      busFault <= 1'b1;
      @(posedge clk);
      busFault <= 1'b0;
      @(posedge clk);
      sampleStrobe <= 1'b1;
      repeat (10) @(posedge clk);
      @(posedge clk);
      acqActive <= 1'b0;
      sampleStrobe <= 1'b0;
      busFault <= 1'b0;
      hold <= 1'b0;
      streamMode <= 1'b0;
      rd(STA);
      chk("overrun", 1, q[extra_dma_pkg::OVERRUN_BIT]);
      chk("bothFlags", 32'h0000_C000, q);
      wr(START);
      wait_idle(200);
      rd(STA);
      chk("restart", 32'h0000_2000, q);
      $display("overrun test done");
   endtask : t_overrun
   task t_setup;
      s(0, 0, 0, 35'h0_0000_0008, 32, 16, 0);
      s(0, 0, 0, 35'h0_0000_0014, 32, 16, 0);
      s(0, 0, 0, 35'h0_0800_0008, 32, 16, 0);
      s(0, 0, 1, 35'h0_0800_0008, 32, 16, 1);
      s(0, 1, 0, 35'h0_0400_0008, 32, 16, 0);
      s(0, 0, 0, 64, 32, 12, 0);
      s(0, 0, 0, 64, 32, 35'h2_0000_0000, 0);
      s(1, 0, 0, 64, 35'h0_0000_2010, 8, 0);
      s(1, 1, 0, 64, 35'h0_0000_1010, 8, 0);
      s(1, 0, 0, 64, 20, 16, 0);
      s(1, 0, 0, 64, 32, 16, 1);
      s(1, 0, 0, 64, 35'h0_0400_0008, 35'h0_0400_0000, 0);
      s(1, 0, 0, 64, 35'h0_0400_0000, 35'h0_03FF_FFF8, 1);
      s(1, 1, 0, 64, 35'h0_0000_1008, 8, 1);
      slowRateDivider <= 18'h0_000C;
      s(0, 0, 0, 64, 32, 16, 0);
      slowRateDivider <= 18'h2_0000;
      s(0, 0, 0, 64, 32, 16, 0);
      slowRateDivider <= 18'h0_0008;
      s(0, 0, 0, 8, 32, 16, 0);
      wr(START);
      chk("refused", 0, running);
      s(0, 0, 0, 64, 32, 16, 1);
      $display("setup test done");
   endtask : t_setup
   task t_poll;
      wr(POLL);
      chk("pollMode", 1, pollMode);
      wr(START);
      chk("noDma", 0, running);
      wr(STOP);
      chk("pollOff", 0, pollMode);
      wr(POLL | START);
      chk("pollStart", 0, running);
      chk("pollSet", 1, pollMode);
      wr(STOP);
      $display("poll test done");
   endtask : t_poll
   task print_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
   initial begin
      {nrst, regWrite, regRead, sampleStrobe, acqActive, tsValid, busFault, hold} = '0;
      {streamMode, multiMode, twoChannels, memSel, regAddr, regWdata, tsData} = '0;
      sampleData = 16'h0123;
      slowRateDivider = 18'h0_0008;
      totalSampleCount = 35'h0_0000_0040;
      segmentLength = 35'h0_0000_0020;
      afterTriggerCount = 35'h0_0000_0010;
      {repeatCount, notifySize, waitTimeout} = '0;
      bufferBase = 32'h0000_0100;
      bufferLength = 32'h0000_0022;
      slow = 1'b1;
      n_fail = 0;
      tests_run = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_fill();
      t_block();
      t_timeout();
      t_overrun();
      t_setup();
      t_poll();
      print_verdict();
   end
endmodule : tb_extra_dma_engine
